// ==== src/gss_selector.sv ====
// Summary of operation
// - Hold base and two alternate coefficient sets.
// - Command word one bit 4 requests first set.
// - Command word five bit 4 requests second set.
// - Status word one bit 4 shows first set.
// - Status word five bit 4 shows second set.
// - Sense 0: above thresholds pick first/second set.
// - Zero second threshold: speed never selects second set.
// - Sense 0, second threshold lower but nonzero: no first set.
// - Sense 1: below second, between first, else base.
// - Sense 1, second threshold higher: no first set.
// - Sense 1, zero second: below first picks first.
// - Alternate model/vibration values only in signal mode.
// - Bypass filter on switching, filter the return.
// - Decode first source selector: only signal and speed act, other values as off.
// - Decode second source: off, signal, same condition.
// - Decode time-constant disabling selector values.
// - Lag filter with per-set millisecond time constants.
`timescale 1ns/10ps
`default_nettype none
`include "gss_regs.svh"

module gss_selector #(
    parameter int FILTER_STEP_CYCLES = `GSS_FILTER_STEP_NS / `GSS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 sys_rst_in,
    // Wishbone slave
    input  wire gss_pkg::gss_wb_req_type wb_req_in,
    output var  logic                 wb_ack_out,
    output var  logic [31:0]          wb_dat_out,
    // Servo loop side
    input  wire logic signed [15:0]   motor_speed_in,
    input  wire logic                 first_switch_input_in,
    input  wire logic                 second_switch_input_in,
    output var  gss_pkg::gss_coef_type coef_out,
    output var  logic                 first_alt_active_flag_out,
    output var  logic                 second_alt_active_flag_out,
    // Interrupt
    output var  logic                 irq_out
);
    import gss_pkg::*;

    typedef struct packed {
        logic [15:0]  ctl_one;
        logic [15:0]  ctl_five;
        logic [15:0]  cfg;
        logic [15:0]  thr1;
        logic [15:0]  thr2;
        logic [15:0]  tc1;
        logic [15:0]  tc2;
        logic [2:0]   irq_stat;
        logic [2:0]   irq_mask;
        logic         irq;
        gss_mem_type  mem;
        gss_set_type  active;
        gss_coef_type coef;
        logic         filt_on;
        logic [15:0]  tc_use;
        logic [15:0]  step_cnt;
        logic [15:0]  cyc_cnt;
        logic [15:0]  div_cnt;
        logic         ctl_tick;
        logic         step_tick;
        logic [1:0]   sync1;
        logic [1:0]   sync2;
        logic [1:0]   sync3;
        logic [1:0]   pin_val;
        logic         ack;
        logic [31:0]  dat;
        logic         flag1;
        logic         flag2;
    } gss_state_type;

    gss_state_type st_reg;
    gss_state_type st_next;

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Chooses the set from the programmed source, sense and thresholds
    function automatic gss_set_type decide(input gss_src_type src, input logic sense,
                                           input gss_src2_type src2, input logic sig1,
                                           input logic sig2, input logic [15:0] spd,
                                           input logic [15:0] t1, input logic [15:0] t2);
        logic f;
        logic s;
        logic use2;
        f = 1'b0;
        s = 1'b0;
        use2 = (src2 == GSS_SRC2_SAME) && (t2 != 16'h0000);
        case (src)
            GSS_SRC_SIGNAL: begin
                f = sense ? !sig1 : sig1;
            end
            GSS_SRC_SPEED: begin
                if (sense) begin
                    f = (spd < t1) && !(use2 && (t2 > t1));
                end else begin
                    f = (spd > t1) && !(use2 && (t2 < t1));
                end
            end
            default: begin
                f = 1'b0; // Frequency, droop and direction sources are not built here
            end
        endcase
        case (src2)
            GSS_SRC2_SIGNAL: begin
                s = sig2;
            end
            GSS_SRC2_SAME: begin
                if (src == GSS_SRC_SIGNAL) begin
                    s = sig2;
                end else if (src == GSS_SRC_SPEED) begin
                    s = use2 && (sense ? (spd < t2) : (spd > t2));
                end else begin
                    s = 1'b0;
                end
            end
            default: begin
                s = 1'b0;
            end
        endcase
        if (s) begin
            return GSS_SET_ALT2;
        end else if (f) begin
            return GSS_SET_ALT1;
        end
        return GSS_SET_BASE;
    endfunction

    // Builds the coefficients that a set puts into effect
    function automatic gss_coef_type target(input gss_set_type set, input gss_mem_type mem,
                                            input logic sigmode);
        gss_coef_type r;
        int           base_i;
        for (int k = 0; k < `GSS_COEF_COUNT; k++) begin
            base_i = `GSS_COEF_COUNT * int'(set); // Sets are stored back to back
            if ((k == 1 || k >= 5) && !sigmode) begin
                r[k] = mem[k];
            end else begin
                r[k] = mem[base_i + k];
            end
        end
        return r;
    endfunction

    // One first-order lag step; snaps once the gap is under one step
    function automatic logic [15:0] lag_step(input logic [15:0] y, input logic [15:0] t);
        logic signed [16:0] d;
        d = $signed({1'b0, t}) - $signed({1'b0, y});
        if (d < 17'sd8 && d > -17'sd8) begin
            return t;
        end
        return 16'($signed({1'b0, y}) + (d >>> `GSS_LAG_SHIFT));
    endfunction

    // Storage slot of a window index, -1 outside it; the bus window leaves a
    // three-word gap after each set, which storage does not keep
    function automatic int coef_slot(input logic [13:0] i);
        if (i[13:6] == `GSS_IDX_COEF_PAGE && i[5:4] != 2'b11 &&
            i[3:0] < 4'(`GSS_COEF_COUNT)) begin
            return `GSS_COEF_COUNT * int'(i[5:4]) + int'(i[3:0]);
        end
        return -1;
    endfunction

    // Decoded configuration and live conditions
    gss_src_type   cfg_src;
    gss_src2_type  cfg_src2;
    gss_tcdis_type cfg_tcdis;
    logic          cfg_sense;
    logic          sig1;
    logic          sig2;
    logic [15:0]   spd_abs;
    logic          sig_mode;
    logic          sig_mode_new;
    gss_set_type   new_set;
    gss_coef_type  tgt_now;
    gss_coef_type  tgt_new;
    logic [13:0]   idx;
    logic          bus_req;

    always_comb begin
        cfg_src   = gss_src_type'(st_reg.cfg[`GSS_CFG_SRC_LSB +: 4]);
        cfg_sense = st_reg.cfg[`GSS_CFG_SENSE_LSB];
        cfg_tcdis = gss_tcdis_type'(st_reg.cfg[`GSS_CFG_TCDIS_LSB +: 4]);
        cfg_src2  = gss_src2_type'(st_reg.cfg[`GSS_CFG_SRC2_LSB +: 4]);
        // Command bit and input pin are ORed, either may request
        sig1 = st_reg.ctl_one[`GSS_SWITCH_CMD_BIT] | st_reg.pin_val[0];
        sig2 = st_reg.ctl_five[`GSS_SWITCH_CMD_BIT] | st_reg.pin_val[1];
        spd_abs = motor_speed_in[15] ? 16'(-motor_speed_in) : 16'(motor_speed_in);
        new_set = decide(cfg_src, cfg_sense, cfg_src2, sig1, sig2, spd_abs,
                         st_reg.thr1, st_reg.thr2);
        sig_mode = (st_reg.active == GSS_SET_ALT2) ?
                   (cfg_src2 == GSS_SRC2_SIGNAL || cfg_src == GSS_SRC_SIGNAL) :
                   (cfg_src == GSS_SRC_SIGNAL);
        sig_mode_new = (new_set == GSS_SET_ALT2) ?
                       (cfg_src2 == GSS_SRC2_SIGNAL || cfg_src == GSS_SRC_SIGNAL) :
                       (cfg_src == GSS_SRC_SIGNAL);
        tgt_now = target(st_reg.active, st_reg.mem, sig_mode);
        tgt_new = target(new_set, st_reg.mem, sig_mode_new);
        idx     = wb_req_in.adr[15:2];
        bus_req = wb_req_in.cyc && wb_req_in.stb;
    end

    // Next-state logic for the whole block
    always_comb begin
        logic [2:0]  ev;
        logic [2:0]  clr;
        logic [31:0] rd;
        logic        wr;
        logic        immediate;
        int          ci;
        st_next   = st_reg;
        ev        = 3'b000;
        clr       = 3'b000;
        rd        = `GSS_DAT_RESET;
        wr        = bus_req && wb_req_in.we && st_reg.ack;
        immediate = 1'b0;
        ci        = 0;

        // Dividers: control cycle tick and filter step tick
        st_next.ctl_tick  = (st_reg.cyc_cnt == 16'(`GSS_CTRL_CYCLES - 1));
        st_next.cyc_cnt   = st_next.ctl_tick ? 16'h0000 : st_reg.cyc_cnt + 16'h0001;
        st_next.step_tick = (st_reg.div_cnt == 16'(FILTER_STEP_CYCLES - 1));
        st_next.div_cnt   = st_next.step_tick ? 16'h0000 : st_reg.div_cnt + 16'h0001;

        // Pin synchronisers; a change counts once stages two and three agree
        st_next.sync1 = {second_switch_input_in, first_switch_input_in};
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        for (int b = 0; b < 2; b++) begin
            if (st_reg.sync2[b] == st_reg.sync3[b]) begin
                st_next.pin_val[b] = st_reg.sync3[b];
            end
        end

        // Set selection happens only on the control cycle tick
        if (st_reg.ctl_tick && new_set != st_reg.active) begin
            st_next.active = new_set;
            case (cfg_tcdis)
                GSS_TC_NO_SWITCH: immediate = (new_set != GSS_SET_BASE);
                GSS_TC_NO_RETURN: immediate = (new_set == GSS_SET_BASE);
                default:          immediate = 1'b0;
            endcase
            // Returning to base filters with the time constant of the set being left
            if (new_set == GSS_SET_ALT2 ||
                (new_set == GSS_SET_BASE && st_reg.active == GSS_SET_ALT2)) begin
                st_next.tc_use = st_reg.tc2;
            end else begin
                st_next.tc_use = st_reg.tc1;
            end
            if (immediate || st_next.tc_use == 16'h0000) begin
                st_next.coef    = tgt_new;
                st_next.filt_on = 1'b0;
            end else begin
                st_next.filt_on  = 1'b1;
                st_next.step_cnt = 16'h0000;
            end
            case (new_set)
                GSS_SET_ALT1: ev[`GSS_IRQ_ENTER_ONE]   = 1'b1;
                GSS_SET_ALT2: ev[`GSS_IRQ_ENTER_TWO]   = 1'b1;
                default:      ev[`GSS_IRQ_RETURN_BASE] = 1'b1;
            endcase
        end else if (st_reg.filt_on && st_reg.step_tick) begin
            // Eight lag steps per time constant, all coefficients step together
            if (st_reg.step_cnt + 16'h0001 >= st_reg.tc_use) begin
                st_next.step_cnt = 16'h0000;
                for (int k = 0; k < `GSS_COEF_COUNT; k++) begin
                    st_next.coef[k] = lag_step(st_reg.coef[k], tgt_now[k]);
                end
                st_next.filt_on = (st_next.coef != tgt_now);
            end else begin
                st_next.step_cnt = st_reg.step_cnt + 16'h0001;
            end
        end

        // Status flags follow the set in effect
        st_next.flag1 = (st_next.active == GSS_SET_ALT1);
        st_next.flag2 = (st_next.active == GSS_SET_ALT2);

        // Register read mux
        case (idx)
            `GSS_IDX_CTRL_ONE:   rd = {16'h0000, st_reg.ctl_one};
            `GSS_IDX_CTRL_FIVE:  rd = {16'h0000, st_reg.ctl_five};
            `GSS_IDX_STAT_ONE:   rd = 32'(st_reg.flag1) << `GSS_ACTIVE_FLAG_BIT;
            `GSS_IDX_STAT_FIVE:  rd = 32'(st_reg.flag2) << `GSS_ACTIVE_FLAG_BIT;
            `GSS_IDX_CONFIG:     rd = {16'h0000, st_reg.cfg};
            `GSS_IDX_THRESH_ONE: rd = {16'h0000, st_reg.thr1};
            `GSS_IDX_THRESH_TWO: rd = {16'h0000, st_reg.thr2};
            `GSS_IDX_TCONST_ONE: rd = {16'h0000, st_reg.tc1};
            `GSS_IDX_TCONST_TWO: rd = {16'h0000, st_reg.tc2};
            `GSS_IDX_IRQ_STATUS: rd = {29'h0000_0000, st_reg.irq_stat};
            `GSS_IDX_IRQ_MASK:   rd = {29'h0000_0000, st_reg.irq_mask};
            default: begin
                ci = coef_slot(idx);
                if (ci >= 0) begin
                    rd = {16'h0000, st_reg.mem[ci]};
                end
            end
        endcase

        // Classic handshake: ack one cycle after the request, dropped the next
        st_next.ack = bus_req && !st_reg.ack;
        if (bus_req && !st_reg.ack) begin
            st_next.dat = rd;
        end
        if (bus_req && st_reg.ack && !wb_req_in.we && idx == `GSS_IDX_IRQ_STATUS) begin
            clr = st_reg.irq_stat;
        end

        // Writes land at the edge where ack is high; unmapped writes are dropped
        if (wr) begin
            case (idx)
                `GSS_IDX_CTRL_ONE:   st_next.ctl_one  = merge16(st_reg.ctl_one,
                                                          wb_req_in.dat, wb_req_in.sel);
                `GSS_IDX_CTRL_FIVE:  st_next.ctl_five = merge16(st_reg.ctl_five,
                                                          wb_req_in.dat, wb_req_in.sel);
                `GSS_IDX_CONFIG:     st_next.cfg  = merge16(st_reg.cfg, wb_req_in.dat,
                                                            wb_req_in.sel);
                `GSS_IDX_THRESH_ONE: st_next.thr1 = merge16(st_reg.thr1, wb_req_in.dat,
                                                            wb_req_in.sel);
                `GSS_IDX_THRESH_TWO: st_next.thr2 = merge16(st_reg.thr2, wb_req_in.dat,
                                                            wb_req_in.sel);
                `GSS_IDX_TCONST_ONE: st_next.tc1  = merge16(st_reg.tc1, wb_req_in.dat,
                                                            wb_req_in.sel);
                `GSS_IDX_TCONST_TWO: st_next.tc2  = merge16(st_reg.tc2, wb_req_in.dat,
                                                            wb_req_in.sel);
                `GSS_IDX_IRQ_MASK: begin
                    if (wb_req_in.sel[0]) begin
                        st_next.irq_mask = wb_req_in.dat[2:0];
                    end
                end
                default: begin
                    ci = coef_slot(idx);
                    if (ci >= 0) begin
                        st_next.mem[ci] = merge16(st_reg.mem[ci], wb_req_in.dat,
                                                  wb_req_in.sel);
                    end
                end
            endcase
        end

        // Sticky events; a new event beats a clearing read in the same cycle
        st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
        st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
    end

    // State register; all fields reset to zero, which is the base set
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign wb_ack_out                 = st_reg.ack;
    assign wb_dat_out                 = st_reg.dat;
    assign coef_out                   = st_reg.coef;
    assign first_alt_active_flag_out  = st_reg.flag1;
    assign second_alt_active_flag_out = st_reg.flag2;
    assign irq_out                    = st_reg.irq;

    // Checks on the selection and on the coefficient hand-over
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    AST_CMD_ONE: assert property (st_reg.ctl_tick && cfg_src == GSS_SRC_SIGNAL && !cfg_sense
        && cfg_src2 == GSS_SRC2_OFF && st_reg.ctl_one[4] |=> st_reg.active == GSS_SET_ALT1)
        else $error("first command bit did not select first set");
    AST_CMD_FIVE: assert property (st_reg.ctl_tick && cfg_src2 == GSS_SRC2_SIGNAL
        && st_reg.ctl_five[4] |=> second_alt_active_flag_out)
        else $error("second command bit did not select second set");
    AST_FLAG_ONE: assert property (first_alt_active_flag_out ==
        (st_reg.active == GSS_SET_ALT1)) else $error("first active flag wrong");
    AST_FLAG_TWO: assert property (wb_ack_out && $past(idx) == `GSS_IDX_STAT_FIVE
        && $past(bus_req) && !$past(wb_ack_out) |-> wb_dat_out[4] == $past(st_reg.flag2))
        else $error("status word five bit 4 wrong");
    AST_SPEED_UP: assert property (st_reg.ctl_tick && cfg_src == GSS_SRC_SPEED && !cfg_sense
        && cfg_src2 == GSS_SRC2_SAME && st_reg.thr2 >= st_reg.thr1 && st_reg.thr2 != 0
        && spd_abs > st_reg.thr2 |=> st_reg.active == GSS_SET_ALT2)
        else $error("speed above second threshold missed second set");
    AST_ZERO_TWO: assert property (st_reg.ctl_tick && cfg_src == GSS_SRC_SPEED
        && cfg_src2 == GSS_SRC2_SAME && st_reg.thr2 == 0 |=> st_reg.active != GSS_SET_ALT2)
        else $error("zero second threshold selected second set");
    AST_LOW_TWO: assert property (st_reg.ctl_tick && cfg_src == GSS_SRC_SPEED && !cfg_sense
        && cfg_src2 == GSS_SRC2_SAME && st_reg.thr2 < st_reg.thr1 && st_reg.thr2 != 0
        |=> st_reg.active != GSS_SET_ALT1) else $error("first set chosen with low second");
    AST_SENSE_BASE: assert property (st_reg.ctl_tick && cfg_src == GSS_SRC_SPEED && cfg_sense
        && cfg_src2 == GSS_SRC2_SAME && st_reg.thr2 <= st_reg.thr1 && spd_abs >= st_reg.thr1
        |=> st_reg.active == GSS_SET_BASE) else $error("base set not used above first");
    AST_SENSE_HIGH: assert property (st_reg.ctl_tick && cfg_src == GSS_SRC_SPEED && cfg_sense
        && cfg_src2 == GSS_SRC2_SAME && st_reg.thr2 > st_reg.thr1
        |=> st_reg.active != GSS_SET_ALT1) else $error("first set chosen with high second");
    AST_NO_FILTER: assert property ($changed(st_reg.active) && st_reg.active != GSS_SET_BASE
        && $past(cfg_tcdis) == GSS_TC_NO_SWITCH && $stable(st_reg.mem) && $stable(st_reg.cfg)
        |-> coef_out == tgt_now) else $error("coefficients not applied at once");
    AST_RETURN_FILTER: assert property ($changed(st_reg.active)
        && st_reg.active == GSS_SET_BASE && $past(cfg_tcdis) == GSS_TC_NO_SWITCH
        && st_reg.tc_use != 16'h0000 |-> $stable(coef_out) && st_reg.filt_on)
        else $error("return to base was not filtered");
    AST_RETURN_AT_ONCE: assert property ($changed(st_reg.active)
        && st_reg.active == GSS_SET_BASE && $past(cfg_tcdis) == GSS_TC_NO_RETURN
        && $stable(st_reg.mem) && $stable(st_reg.cfg) |-> coef_out == tgt_now)
        else $error("return to base not applied at once");
    AST_ONCE_PER_CYCLE: assert property (!$past(st_reg.ctl_tick) |-> $stable(st_reg.active))
        else $error("set changed outside the control cycle tick");

endmodule // gss_selector

`default_nettype wire

// ==== src/gss_regs.svh ====
`ifndef GSS_REGS_SVH
`define GSS_REGS_SVH

// Register indices; byte address is four times the index
`define GSS_IDX_CTRL_ONE      14'h2d01
`define GSS_IDX_CTRL_FIVE     14'h2d05
`define GSS_IDX_STAT_ONE      14'h2d11
`define GSS_IDX_STAT_FIVE     14'h2d15
`define GSS_IDX_CONFIG        14'h2d20
`define GSS_IDX_THRESH_ONE    14'h2d21
`define GSS_IDX_THRESH_TWO    14'h2d22
`define GSS_IDX_TCONST_ONE    14'h2d23
`define GSS_IDX_TCONST_TWO    14'h2d24
`define GSS_IDX_IRQ_STATUS    14'h2d25
`define GSS_IDX_IRQ_MASK      14'h2d26
// Coefficient window: index = base + set * 16 + coefficient
`define GSS_IDX_COEF_PAGE     8'hb8
`define GSS_COEF_COUNT        13
`define GSS_SET_COUNT         3

// Bit fields
`define GSS_SWITCH_CMD_BIT    4
`define GSS_ACTIVE_FLAG_BIT   4
`define GSS_CFG_SRC_LSB       0
`define GSS_CFG_SENSE_LSB     4
`define GSS_CFG_TCDIS_LSB     8
`define GSS_CFG_SRC2_LSB      12
`define GSS_IRQ_ENTER_ONE     0
`define GSS_IRQ_ENTER_TWO     1
`define GSS_IRQ_RETURN_BASE   2

// Reset values
`define GSS_REG_RESET         16'h0000
`define GSS_DAT_RESET         32'h0000_0000

// Timing
`define GSS_CLK_PERIOD_NS     5
`define GSS_CTRL_CYCLE_NS     1000
`define GSS_CTRL_CYCLES       (`GSS_CTRL_CYCLE_NS / `GSS_CLK_PERIOD_NS)
`define GSS_FILTER_STEP_NS    125000
`define GSS_FILTER_STEPS_PER_MS 8
`define GSS_LAG_SHIFT         3

`endif

// ==== src/gss_pkg.sv ====
package gss_pkg;

    // Active coefficient set
    typedef enum logic [1:0] {
        GSS_SET_BASE = 2'b00,
        GSS_SET_ALT1 = 2'b01,
        GSS_SET_ALT2 = 2'b10
    } gss_set_type;

    // Switching source selector
    typedef enum logic [3:0] {
        GSS_SRC_OFF    = 4'h0,
        GSS_SRC_SIGNAL = 4'h1,
        GSS_SRC_FREQ   = 4'h2,
        GSS_SRC_DROOP  = 4'h3,
        GSS_SRC_SPEED  = 4'h4,
        GSS_SRC_DIR    = 4'h5
    } gss_src_type;

    // Second switching source selector
    typedef enum logic [3:0] {
        GSS_SRC2_OFF    = 4'h0,
        GSS_SRC2_SIGNAL = 4'h1,
        GSS_SRC2_SAME   = 4'h2
    } gss_src2_type;

    // Time-constant disabling selector
    typedef enum logic [3:0] {
        GSS_TC_BOTH      = 4'h0,
        GSS_TC_NO_SWITCH = 4'h1,
        GSS_TC_NO_RETURN = 4'h2
    } gss_tcdis_type;

    // One coefficient set: 0 inertia, 1 model, 2 position, 3 speed, 4 integral, 5..12 vibration
    typedef logic [12:0][15:0] gss_coef_type;
    typedef logic [38:0][15:0] gss_mem_type;

    // Wishbone classic request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [15:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gss_wb_req_type;

endpackage : gss_pkg

// ==== tb/gss_io_device.sv ====
`timescale 1ns/10ps
`default_nettype none

module gss_io_device (
    // Clock and press requests
    input  wire logic       clock_in,
    input  wire logic [1:0] press_in,
    // Switch pins
    output var  logic       first_sw_out,
    output var  logic       second_sw_out
);
    // Pins follow presses one cycle late, like a contact behind an input stage
    always_ff @(posedge clock_in) begin
        first_sw_out  <= press_in[0];
        second_sw_out <= press_in[1];
    end
endmodule // gss_io_device
`default_nettype wire

// ==== tb/test_gss_selector.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_gss_selector;
    import gss_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ack, f1, f2, irq, p1, p2;
    logic [1:0] press = 2'b00;
    logic signed [15:0] spd = '0;
    logic [31:0] rd, dat;
    gss_wb_req_type req = '0;
    gss_coef_type coef;
    int fails = 0, num_checks = 0;
    logic [63:0] tv [10];
    logic [1:0] te [10];

    gss_io_device dev (.clock_in(clk), .press_in(press), .first_sw_out(p1), .second_sw_out(p2));
    gss_selector #(.FILTER_STEP_CYCLES(10)) dut (.clock_in(clk), .sys_rst_in(rst),
        .wb_req_in(req), .wb_ack_out(ack), .wb_dat_out(dat), .motor_speed_in(spd),
        .first_switch_input_in(p1), .second_switch_input_in(p2), .coef_out(coef),
        .first_alt_active_flag_out(f1), .second_alt_active_flag_out(f2), .irq_out(irq));

    // Clock of 5 ns
    always #2.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; holds the request until ack, the watchdog ends a dead wait
    task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] wd);
        req <= '{cyc:1'b1, stb:1'b1, we:we, adr:{idx[13:0], 2'b00}, sel:4'h3, dat:{16'h0, wd}};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat;
        req <= '0;
        @(posedge clk);
    endtask

    task automatic final_report();
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog sized well above the ~9000 cycles of the sequence
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        final_report();
    end

    // Main sequence
    initial begin
        tv = '{64'h2004_0064_00c8_ff6a, 64'h2004_0064_00c8_00fa, 64'h2004_0064_0000_00fa,
               64'h2004_0064_0032_0096, 64'h2014_00c8_0064_0032, 64'h2014_00c8_0064_0096,
               64'h2014_00c8_0064_00fa, 64'h2014_0064_012c_0096, 64'h2014_00c8_0000_0096,
               64'h0003_0064_0000_00fa};
        te = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b10, 2'b01, 2'b00, 2'b10, 2'b01, 2'b00};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, 16'h2d11, 0); chk(rd, 0);
        bus(0, 16'h2d30, 0); chk(rd, 0);
        bus(1, 16'h2d26, 16'h0007);
        bus(1, 16'h2e11, 16'h0abc);
        bus(1, 16'h2e12, 16'h1234);
        bus(1, 16'h2d23, 16'h0002);
        bus(1, 16'h2d20, 16'h0101);
        bus(1, 16'h2d01, 16'h0010);
        repeat (450) @(posedge clk);
        bus(0, 16'h2d11, 0); chk(rd, 32'h0000_0010);
        chk({f2, f1}, 2'b01);
        chk(coef[2], 16'h1234);
        chk(coef[1], 16'h0abc);
        chk(irq, 1'b1);
        bus(0, 16'h2d25, 0); chk(rd, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        bus(1, 16'h2d01, 16'h0000);
        press <= 2'b01;
        repeat (450) @(posedge clk);
        chk({f2, f1}, 2'b01);
        press <= 2'b00;
        bus(1, 16'h2d20, 16'h1101);
        bus(1, 16'h2d05, 16'h0010);
        repeat (450) @(posedge clk);
        bus(0, 16'h2d15, 0); chk(rd, 32'h0000_0010);
        chk({f2, f1}, 2'b10);
        bus(1, 16'h2d05, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            bus(1, 16'h2d20, tv[i][63:48]);
            bus(1, 16'h2d21, tv[i][47:32]);
            bus(1, 16'h2d22, tv[i][31:16]);
            spd <= tv[i][15:0];
            repeat (450) @(posedge clk);
            chk({f2, f1}, te[i]);
            if (i == 0) chk(coef[1], 16'h0000);
        end
        // Equal inertia in base and first set; bypass on switching, filtered return
        bus(1, 16'h2e00, 16'h0040);
        bus(1, 16'h2e10, 16'h0040);
        bus(1, 16'h2d20, 16'h0101);
        bus(1, 16'h2d01, 16'h0010);
        repeat (450) @(posedge clk);
        chk({f2, f1}, 2'b01);
        chk(coef[2], 16'h1234);
        chk(coef[0], 16'h0040);
        bus(1, 16'h2d01, 16'h0000);
        repeat (1600) @(posedge clk);
        chk({f2, f1}, 2'b00);
        chk(coef[2], 16'h0000);
        chk(coef[0], 16'h0040);
        // Filtered switching, return at once
        bus(1, 16'h2d20, 16'h0201);
        bus(1, 16'h2d01, 16'h0010);
        repeat (450) @(posedge clk);
        chk({f2, f1}, 2'b01);
        bus(1, 16'h2d01, 16'h0000);
        repeat (450) @(posedge clk);
        chk(coef[2], 16'h0000);
        final_report();
    end
endmodule // test_gss_selector
`default_nettype wire
